// File: hw/obcd_defs.vh
// register offsets, field positions and reset values of the option byte decoder
`ifndef OBCD_DEFS_VH
`define OBCD_DEFS_VH
`define OBCD_ADDR_W        4
`define OBCD_ADDR_OPT0     4'h0
`define OBCD_ADDR_OPT1     4'h1
`define OBCD_ADDR_CTRL     4'h2
`define OBCD_ADDR_STAT     4'h3
`define OBCD_ADDR_ERASE    4'h4
`define OBCD_ADDR_DEC0     4'h5
`define OBCD_ADDR_DEC1     4'h6
`define OBCD_OPT0_RESET    8'hFC
`define OBCD_OPT1_RESET    8'hEF
`define OBCD_OPT0_RSVD     8'hF0
`define OBCD_OPT1_RSVD     8'h20
`define OBCD_B0_SIZE_HI    3
`define OBCD_B0_SIZE_LO    2
`define OBCD_B0_RDPROT     1
`define OBCD_B0_WLOCK      0
`define OBCD_B1_MULSEL     7
`define OBCD_B1_BYPASS     6
`define OBCD_B1_RCOFF      4
`define OBCD_B1_BO_HI      3
`define OBCD_B1_BO_LO      2
`define OBCD_B1_SOFTEN     1
`define OBCD_B1_HALTRST    0
`define OBCD_SIZE_HALF     2'h0
`define OBCD_SIZE_ONE      2'h1
`define OBCD_SIZE_ONEHALF  2'h2
`define OBCD_BO_OFF        2'h3
`define OBCD_BO_HIGH       2'h2
`define OBCD_BO_MED        2'h1
`define OBCD_BO_LOW        2'h0
`define OBCD_ERASE_KEY     8'hA5
`define OBCD_MEM_AW        10
`define OBCD_MEM_WORDS     1024
`define OBCD_ERASE_VAL     8'hFF
`endif

// File: hw/obcd_sync.v
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module obcd_sync (
  // clock and reset
  input  wire CLK,
  input  wire RST_B,
  // async level in, filtered level out
  input  wire d,
  output reg  q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule // obcd_sync

// File: hw/obcd_mem.v
// program memory array with registered read data
`timescale 1ns/1ps
`include "obcd_defs.vh"
module obcd_mem (
  // clock
  input  wire                     CLK,
  // write port
  input  wire                     we,
  input  wire [`OBCD_MEM_AW-1:0]  waddr,
  input  wire [7:0]               wdata,
  // read port
  input  wire [`OBCD_MEM_AW-1:0]  raddr,
  output reg  [7:0]               rdata
);
  reg [7:0] mem [0:`OBCD_MEM_WORDS-1];
  always @(posedge CLK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // obcd_mem

// File: hw/obcd_top.v
// option byte store, program memory guard and decoded configuration outputs
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "obcd_defs.vh"
module obcd_top (
  // clock and reset
  input  wire                    CLK,
  input  wire                    RST_B,
  // programming mode pin
  input  wire                    PROG_MODE,
  // register port
  input  wire [`OBCD_ADDR_W-1:0] ADDR,
  input  wire [7:0]              WDATA,
  input  wire                    WR,
  input  wire                    RD,
  output reg  [7:0]              RDATA,
  // program memory port from the core
  input  wire [`OBCD_MEM_AW-1:0] MEM_ADDR,
  input  wire [7:0]              MEM_WDATA,
  input  wire                    MEM_WR,
  input  wire                    MEM_RD,
  input  wire                    MEM_EXT,
  output wire [7:0]              MEM_RDATA,
  output wire                    MEM_REFUSED,
  // decoded configuration and erase busy flag
  output reg  [1:0]              BOOT_AREA_SIZE,
  output reg                     READOUT_PROTECT,
  output reg                     WRITE_LOCK,
  output reg                     MUL_BY_EIGHT,
  output reg                     MULTIPLIER_BYPASS,
  output reg                     RC_OSC_OFF,
  output reg                     BROWNOUT_ENABLE,
  output reg  [1:0]              BROWNOUT_THRESHOLD_SEL,
  output reg                     SUPERVISOR_HW_ENABLE,
  output reg                     SUPERVISOR_RESET_ON_HALT,
  output wire                    ERASE_BUSY
);
  // control states
  localparam ST_IDLE  = 1'b0;
  localparam ST_ERASE = 1'b1;

  wire                    prog_mode;
  reg  [7:0]              opt0_q;
  reg  [7:0]              opt0_d;
  reg  [7:0]              opt1_q;
  reg  [7:0]              opt1_d;
  reg                     state_q;
  reg                     state_d;
  reg  [`OBCD_MEM_AW-1:0] cnt_q;
  reg  [`OBCD_MEM_AW-1:0] cnt_d;
  reg                     opt_erase_q;
  reg                     opt_erase_d;
  reg                     latched_q;
  reg                     blocked_q;
  reg                     refused_q;
  reg                     refused_d;
  wire [7:0]              mem_rdata;
  wire                    sw_mem_wr;
  wire                    mem_we;
  wire [`OBCD_MEM_AW-1:0] mem_waddr;
  wire [7:0]              mem_wdata;
  wire                    opt_acc;
  wire                    erase_req;

  obcd_sync u_sync (
    .CLK   (CLK),
    .RST_B (RST_B),
    .d     (PROG_MODE),
    .q     (prog_mode)
  );

  assign opt_acc   = prog_mode && (state_q == ST_IDLE);
  assign erase_req = opt_acc && WR && (ADDR == `OBCD_ADDR_ERASE) && (WDATA == `OBCD_ERASE_KEY);
  // memory program is refused under write lock or readout protection
  assign sw_mem_wr = MEM_WR && !opt0_q[`OBCD_B0_WLOCK] && !opt0_q[`OBCD_B0_RDPROT] && (state_q == ST_IDLE);
  assign mem_we    = (state_q == ST_ERASE) || sw_mem_wr;
  assign mem_waddr = (state_q == ST_ERASE) ? cnt_q : MEM_ADDR;
  assign mem_wdata = (state_q == ST_ERASE) ? `OBCD_ERASE_VAL : MEM_WDATA;
  assign ERASE_BUSY  = (state_q == ST_ERASE);
  assign MEM_REFUSED = refused_q;
  // external extraction reads FFh under protection
  assign MEM_RDATA = blocked_q ? `OBCD_ERASE_VAL : mem_rdata;

  obcd_mem u_mem (
    .CLK   (CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (MEM_ADDR),
    .rdata (mem_rdata)
  );

  // option byte writes, erase sequencing
  always @* begin
    opt0_d      = opt0_q;
    opt1_d      = opt1_q;
    state_d     = state_q;
    cnt_d       = cnt_q;
    opt_erase_d = opt_erase_q;
    refused_d   = MEM_WR && !sw_mem_wr;
    case (state_q)
      ST_IDLE: begin
        if (opt_acc && WR && !opt0_q[`OBCD_B0_WLOCK]) begin
          if (ADDR == `OBCD_ADDR_OPT0) begin
            opt0_d = WDATA | `OBCD_OPT0_RSVD;
          end
          if (ADDR == `OBCD_ADDR_OPT1) begin
            opt1_d = WDATA | `OBCD_OPT1_RSVD;
          end
          if (erase_req) begin
            if (opt0_q[`OBCD_B0_RDPROT]) begin
              state_d     = ST_ERASE;
              cnt_d       = {`OBCD_MEM_AW{1'b0}};
              opt_erase_d = 1'b1;
            end else begin
              // erased options leave both protections off so the part stays reprogrammable
              opt0_d = `OBCD_OPT0_RESET;
              opt1_d = `OBCD_OPT1_RESET;
            end
          end
        end
      end
      ST_ERASE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == {`OBCD_MEM_AW{1'b1}}) begin
          state_d     = ST_IDLE;
          opt_erase_d = 1'b0;
          opt0_d      = `OBCD_OPT0_RESET;
          opt1_d      = `OBCD_OPT1_RESET;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      opt0_q      <= `OBCD_OPT0_RESET;
      opt1_q      <= `OBCD_OPT1_RESET;
      state_q     <= ST_IDLE;
      cnt_q       <= {`OBCD_MEM_AW{1'b0}};
      opt_erase_q <= 1'b0;
      refused_q   <= 1'b0;
      blocked_q   <= 1'b0;
    end else begin
      opt0_q      <= opt0_d;
      opt1_q      <= opt1_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      opt_erase_q <= opt_erase_d;
      refused_q   <= refused_d;
      blocked_q   <= MEM_EXT && opt0_q[`OBCD_B0_RDPROT];
    end
  end

  // decode once after reset release, then hold
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      latched_q                <= 1'b0;
      BOOT_AREA_SIZE           <= `OBCD_SIZE_HALF;
      READOUT_PROTECT          <= 1'b0;
      WRITE_LOCK               <= 1'b0;
      MUL_BY_EIGHT             <= 1'b0;
      MULTIPLIER_BYPASS        <= 1'b0;
      RC_OSC_OFF               <= 1'b0;
      BROWNOUT_ENABLE          <= 1'b0;
      BROWNOUT_THRESHOLD_SEL   <= `OBCD_BO_OFF;
      SUPERVISOR_HW_ENABLE     <= 1'b0;
      SUPERVISOR_RESET_ON_HALT <= 1'b0;
    end else if (!latched_q) begin
      latched_q <= 1'b1;
      if (opt0_q[`OBCD_B0_SIZE_HI]) begin
        BOOT_AREA_SIZE <= `OBCD_SIZE_ONEHALF;
      end else if (opt0_q[`OBCD_B0_SIZE_LO]) begin
        BOOT_AREA_SIZE <= `OBCD_SIZE_ONE;
      end else begin
        BOOT_AREA_SIZE <= `OBCD_SIZE_HALF;
      end
      READOUT_PROTECT          <= opt0_q[`OBCD_B0_RDPROT];
      WRITE_LOCK               <= opt0_q[`OBCD_B0_WLOCK];
      MUL_BY_EIGHT             <= opt1_q[`OBCD_B1_MULSEL];
      MULTIPLIER_BYPASS        <= opt1_q[`OBCD_B1_BYPASS];
      RC_OSC_OFF               <= opt1_q[`OBCD_B1_RCOFF];
      BROWNOUT_THRESHOLD_SEL   <= opt1_q[`OBCD_B1_BO_HI:`OBCD_B1_BO_LO];
      BROWNOUT_ENABLE          <= (opt1_q[`OBCD_B1_BO_HI:`OBCD_B1_BO_LO] != `OBCD_BO_OFF);
      SUPERVISOR_HW_ENABLE     <= !opt1_q[`OBCD_B1_SOFTEN];
      SUPERVISOR_RESET_ON_HALT <= opt1_q[`OBCD_B1_HALTRST];
    end
  end

  // register reads, one cycle later, option bytes only in programming mode
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `OBCD_ADDR_OPT0: RDATA <= opt_acc ? opt0_q : 8'h00;
          `OBCD_ADDR_OPT1: RDATA <= opt_acc ? opt1_q : 8'h00;
          `OBCD_ADDR_STAT: RDATA <= {4'h0, refused_q, opt_erase_q, latched_q, prog_mode};
          `OBCD_ADDR_DEC0: RDATA <= {4'h0, BOOT_AREA_SIZE, READOUT_PROTECT, WRITE_LOCK};
          `OBCD_ADDR_DEC1: RDATA <= {MUL_BY_EIGHT, MULTIPLIER_BYPASS, BROWNOUT_ENABLE, RC_OSC_OFF,
                                     BROWNOUT_THRESHOLD_SEL, SUPERVISOR_HW_ENABLE, SUPERVISOR_RESET_ON_HALT};
          default:         RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // obcd_top

// File: dv/obcd_props.sv
// port checker for the option byte decoder
`timescale 1ns/1ps
module obcd_props (
  // clock, reset and register port
  input wire       CLK, RST_B, PROG_MODE, RD,
  input wire [3:0] ADDR,
  input wire [7:0] RDATA,
  // memory guard
  input wire       MEM_WR, MEM_REFUSED, ERASE_BUSY,
  // decoded configuration
  input wire [1:0] BOOT_AREA_SIZE, BROWNOUT_THRESHOLD_SEL,
  input wire       READOUT_PROTECT, WRITE_LOCK, MUL_BY_EIGHT, MULTIPLIER_BYPASS, RC_OSC_OFF,
  input wire       BROWNOUT_ENABLE, SUPERVISOR_HW_ENABLE, SUPERVISOR_RESET_ON_HALT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire [7:0]  dec0 = {4'h0, BOOT_AREA_SIZE, READOUT_PROTECT, WRITE_LOCK};
  wire [7:0]  dec1 = {MUL_BY_EIGHT, MULTIPLIER_BYPASS, BROWNOUT_ENABLE, RC_OSC_OFF,
                      BROWNOUT_THRESHOLD_SEL, SUPERVISOR_HW_ENABLE, SUPERVISOR_RESET_ON_HALT};
  reg  [10:0] busy_q;
  // length of the current erase run
  always @(posedge CLK or negedge RST_B)
    if (!RST_B)
      busy_q <= 11'h000;
    else
      busy_q <= ERASE_BUSY ? busy_q + 11'h001 : 11'h000;
  dec0_view_a: assert property (RD && ADDR == 4'h5 |=> RDATA == dec0)
    else $error("decode view 0 mismatch");
  dec1_view_a: assert property (RD && ADDR == 4'h6 |=> RDATA == dec1)
    else $error("decode view 1 mismatch");
  mode_gate_a: assert property (!PROG_MODE [*6] ##0 (RD && ADDR < 4'h2) |=> RDATA == 8'h00)
    else $error("option read outside programming mode");
  brownout_on_a: assert property (BROWNOUT_ENABLE == (BROWNOUT_THRESHOLD_SEL != 2'h3))
    else $error("brownout enable disagrees with field");
  refuse_cause_a: assert property (MEM_REFUSED |-> $past(MEM_WR))
    else $error("refusal without a write");
  erase_block_a: assert property (ERASE_BUSY && MEM_WR |=> MEM_REFUSED)
    else $error("write taken during erase");
  erase_span_a: assert property ($fell(ERASE_BUSY) |-> busy_q >= 11'h400 && busy_q <= 11'h406)
    else $error("erase length wrong");
  cfg_static_a: assert property ($past(RST_B, 2) |-> $stable({dec0, dec1}))
    else $error("configuration moved after latch");
  cover property ($fell(ERASE_BUSY));
  cover property (MEM_REFUSED);
  cover property (RD && ADDR == 4'h6);
endmodule // obcd_props
bind obcd_top obcd_props u_props (.*);

// File: dv/obcd_tool.sv
// programming tool model on the option register port
`timescale 1ns/1ps
module obcd_tool #(
  // supply range of the target: 0 lower, 1 upper
  parameter HIGH_RANGE = 1'b0
) (
  // clock and answer
  input  wire       CLK,
  input  wire [7:0] RDATA,
  // requests toward the device
  output reg        PROG_MODE = 1'b0,
  output reg  [3:0] ADDR      = 4'h0,
  output reg  [7:0] WDATA     = 8'h00,
  output reg        WR        = 1'b0,
  output reg        RD        = 1'b0
);
  // mode change, then wait out the synchroniser
  task mode(input m);
    begin
      @(posedge CLK);
      PROG_MODE <= m;
      repeat (6) @(posedge CLK);
    end
  endtask
  task put(input [3:0] a, input [7:0] d);
    reg [7:0] w;
    begin
      w = d;
      if (a == 4'h0)
        w[7:4] = 4'hF;
      if (a == 4'h1)
        w = {w[6] | HIGH_RANGE, w[6], 1'b1, w[4:0]};
      @(posedge CLK);
      ADDR <= a;
      WDATA <= w;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      WDATA <= ~w;
    end
  endtask
  task get(input [3:0] a, output [7:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      d = RDATA;
    end
  endtask
endmodule // obcd_tool

// File: dv/option_byte_config_decoder_tb.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module option_byte_config_decoder_tb;
  reg        CLK, RST_B, MEM_WR, MEM_RD, MEM_EXT;
  reg  [9:0] MEM_ADDR;
  reg  [7:0] MEM_WDATA, v;
  wire [7:0] RDATA, WDATA, MEM_RDATA;
  wire [3:0] ADDR;
  wire [1:0] BOOT_AREA_SIZE, BROWNOUT_THRESHOLD_SEL;
  wire       PROG_MODE, WR, RD, MEM_REFUSED, ERASE_BUSY, READOUT_PROTECT, WRITE_LOCK, MUL_BY_EIGHT;
  wire       MULTIPLIER_BYPASS, RC_OSC_OFF, BROWNOUT_ENABLE, SUPERVISOR_HW_ENABLE, SUPERVISOR_RESET_ON_HALT;
  integer    bad_count, checks_done, n;
  obcd_tool TOOL (.*);
  obcd_top DUT (.*);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one memory cycle; result sampled in the answer cycle
  task mem(input w, input e, input [9:0] a, input [7:0] d);
    begin
      @(posedge CLK);
      {MEM_ADDR, MEM_WDATA, MEM_WR, MEM_RD, MEM_EXT} <= {a, d, w, !w, e};
      @(posedge CLK);
      {MEM_WR, MEM_RD, MEM_EXT} <= 3'h0;
      @(negedge CLK);
    end
  endtask
  task dec_chk;
    begin
      chk({4'h0, BOOT_AREA_SIZE, READOUT_PROTECT, WRITE_LOCK}, 8'h08);
      chk({MUL_BY_EIGHT, MULTIPLIER_BYPASS, BROWNOUT_ENABLE, RC_OSC_OFF, BROWNOUT_THRESHOLD_SEL,
           SUPERVISOR_HW_ENABLE, SUPERVISOR_RESET_ON_HALT}, 8'hCD);
    end
  endtask
  task t_reset;
    begin
      dec_chk;
      TOOL.get(4'h0, v);
      chk(v, 8'h00);
      TOOL.get(4'h5, v);
      chk(v, 8'h08);
      TOOL.get(4'h6, v);
      chk(v, 8'hCD);
      TOOL.mode(1'b1);
      TOOL.get(4'h1, v);
      chk(v, 8'hEF);
      mem(1'b1, 1'b0, 10'h003, 8'h5A);
      chk({7'h00, MEM_REFUSED}, 8'h00);
      mem(1'b0, 1'b1, 10'h003, 8'h00);
      chk(MEM_RDATA, 8'h5A);
    end
  endtask
  task t_protect;
    begin
      TOOL.put(4'h0, 8'h06);
      TOOL.get(4'h0, v);
      chk(v, 8'hF6);
      TOOL.put(4'h1, 8'h14);
      TOOL.get(4'h1, v);
      chk(v, 8'h34);
      dec_chk;
      mem(1'b0, 1'b1, 10'h003, 8'h00);
      chk(MEM_RDATA, 8'hFF);
      mem(1'b1, 1'b0, 10'h005, 8'h00);
      chk({7'h00, MEM_REFUSED}, 8'h01);
    end
  endtask
  task t_erase;
    begin
      TOOL.put(4'h4, 8'hA5);
      @(negedge CLK);
      chk({7'h00, ERASE_BUSY}, 8'h01);
      mem(1'b1, 1'b0, 10'h007, 8'h11);
      chk({7'h00, MEM_REFUSED}, 8'h01);
      for (n = 0; n < 1100 && ERASE_BUSY !== 1'b0; n = n + 1)
        @(posedge CLK);
      mem(1'b0, 1'b0, 10'h003, 8'h00);
      chk(MEM_RDATA, 8'hFF);
      TOOL.put(4'h0, 8'h00);
      TOOL.get(4'h0, v);
      chk(v, 8'hF0);
      mem(1'b1, 1'b0, 10'h003, 8'h00);
      chk({7'h00, MEM_REFUSED}, 8'h00);
      TOOL.put(4'h0, 8'h01);
      TOOL.put(4'h0, 8'h00);
      TOOL.get(4'h0, v);
      chk(v, 8'hF1);
      mem(1'b1, 1'b0, 10'h003, 8'h00);
      chk({7'h00, MEM_REFUSED}, 8'h01);
    end
  endtask
  task t_rst2;
    begin
      RST_B <= 1'b0;
      repeat (8) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (8) @(posedge CLK);
      dec_chk;
      mem(1'b1, 1'b0, 10'h003, 8'h3C);
      mem(1'b0, 1'b1, 10'h003, 8'h00);
      chk(MEM_RDATA, 8'h3C);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    #250000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    {RST_B, MEM_WR, MEM_RD, MEM_EXT, MEM_ADDR, MEM_WDATA} = 0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (8) @(posedge CLK);
    t_reset;
    t_protect;
    t_erase;
    t_rst2;
    complete_run;
  end
endmodule // option_byte_config_decoder_tb
